// ==== design/kms_ptr_step.sv ====
// Finds the next nonzero slot after the current one, wrapping.
`timescale 1ns/100ps
module kms_ptr_step (
    kms_ptr_if.step ptr
);
    logic [kms_pkg::KMS_SLOTS-1:0] nz;

    genvar g;
    generate
        for (g = 0; g < kms_pkg::KMS_SLOTS; g++) begin : g_nz
            assign nz[g] = (ptr.sel[g*kms_pkg::KMS_DIGIT_W +: kms_pkg::KMS_DIGIT_W] != 4'h0);
        end
    endgenerate

    assign ptr.any_nz = |nz;

    always_comb begin
        logic       found;
        logic [1:0] cand;
        found   = 1'b0;
        cand    = ptr.cur;
        ptr.nxt = ptr.cur;
        for (int k = 1; k <= kms_pkg::KMS_SLOTS; k++) begin
            cand = ptr.cur + k[1:0];
            if (!found && nz[cand]) begin
                found   = 1'b1;
                ptr.nxt = cand;
            end
        end
    end
endmodule

// ==== design/kms_sync.sv ====
// Two flip-flop synchroniser for a group of pin levels.
`timescale 1ns/100ps
module kms_sync #(
    parameter int WIDTH = 4
) (
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_ff;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta_ff  <= '0;
            sync_out <= '0;
        end else begin
            meta_ff  <= async_in;
            sync_out <= meta_ff;
        end
    end
endmodule

// ==== design/kms_top.sv ====
// Keypad monitor selector: slot pointer, quick edit, load speed readout, APB registers.
`timescale 1ns/100ps
module kms_top (
    input  wire logic        clk_sys_in,
    input  wire logic        rst_n_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [7:0]  paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    input  wire logic        key_shift_in,
    input  wire logic        key_enter_in,
    input  wire logic        running_in,
    input  wire logic        monitor_screen_in,
    input  wire logic        freq_shown_in,
    input  wire logic [15:0] speed_monitor_in,
    output logic      [1:0]  display_slot_out,
    output logic      [2:0]  display_source_out,
    output logic             quick_edit_req_out,
    output logic      [1:0]  quick_edit_target_out,
    output logic      [15:0] load_speed_out,
    output logic      [1:0]  decimal_places_out,
    output logic             speed_unit_rpm_out
);
    logic        rst_meta_ff;
    logic        rst_sync_ff;
    logic [3:0]  pins_s;
    logic        shift_s, enter_s, run_s, mon_s;
    logic        shift_d_ff, enter_d_ff, run_d_ff, mon_d_ff;
    logic        shift_rise, enter_rise, state_evt;
    logic [15:0] run_sel_ff, stop_sel_ff, pers_ff, factor_ff, decimals_ff, unit_ff;
    logic [15:0] readout_ff;
    logic [1:0]  ptr_run_ff, ptr_stop_ff, act_ptr;
    logic [15:0] act_sel;
    logic [3:0]  cur_nib;
    logic [3:0]  qe_target, ptr_mode;
    logic        acc, wr_en, mapped;
    logic [31:0] rd_mux;
    logic [31:0] product_ff;
    logic [41:0] scaled;
    logic [41:0] quotient;
    logic [9:0]  pow_sel;
    logic [15:0] wdata16;

    kms_ptr_if ptr_bus ();

    // Reset is released through two flip-flops; everything else uses the copy.
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    kms_sync #(.WIDTH(4)) u_sync (
        .clk_in   (clk_sys_in),
        .rst_n_in (rst_sync_ff),
        .async_in ({key_shift_in, key_enter_in, running_in, monitor_screen_in}),
        .sync_out (pins_s)
    );

    assign shift_s = pins_s[3];
    assign enter_s = pins_s[2];
    assign run_s   = pins_s[1];
    assign mon_s   = pins_s[0];

    always_ff @(posedge clk_sys_in or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            shift_d_ff <= 1'b0;
            enter_d_ff <= 1'b0;
            run_d_ff   <= 1'b0;
            mon_d_ff   <= 1'b0;
        end else begin
            shift_d_ff <= shift_s;
            enter_d_ff <= enter_s;
            run_d_ff   <= run_s;
            mon_d_ff   <= mon_s;
        end
    end

    assign shift_rise = shift_s && !shift_d_ff;
    assign enter_rise = enter_s && !enter_d_ff;
    // Entering the monitoring screen or a run/stop change both count as a screen change.
    assign state_evt  = (mon_s && !mon_d_ff) || (run_s != run_d_ff);

    assign qe_target = pers_ff[3:0];
    assign ptr_mode  = pers_ff[7:4];

    function automatic logic [15:0] clamp_sel(input logic [15:0] v);
        logic [15:0] r;
        r = v;
        for (int i = 0; i < kms_pkg::KMS_SLOTS; i++) begin
            if (v[i*4 +: 4] > kms_pkg::KMS_DIGIT_MAX) begin
                r[i*4 +: 4] = kms_pkg::KMS_DIGIT_MAX;
            end
        end
        return r;
    endfunction

    function automatic logic [15:0] clamp_rng(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
        logic [15:0] r;
        r = v;
        if (v < lo) begin
            r = lo;
        end else if (v > hi) begin
            r = hi;
        end
        return r;
    endfunction

    // APB slave: one wait state, so each transfer takes setup plus two access cycles.
    assign acc     = psel_in && penable_in;
    assign wr_en   = acc && pready_out && pwrite_in;
    assign wdata16 = pwdata_in[15:0];

    always_comb begin
        mapped = 1'b1;
        rd_mux = 32'h0000_0000;
        unique case (paddr_in)
            kms_pkg::KMS_OFS_RUN_SEL:  rd_mux = {16'h0000, run_sel_ff};
            kms_pkg::KMS_OFS_STOP_SEL: rd_mux = {16'h0000, stop_sel_ff};
            kms_pkg::KMS_OFS_PERS:     rd_mux = {16'h0000, pers_ff};
            kms_pkg::KMS_OFS_FACTOR:   rd_mux = {16'h0000, factor_ff};
            kms_pkg::KMS_OFS_DECIMALS: rd_mux = {16'h0000, decimals_ff};
            kms_pkg::KMS_OFS_READOUT:  rd_mux = {16'h0000, readout_ff};
            kms_pkg::KMS_OFS_UNIT:     rd_mux = {16'h0000, unit_ff};
            kms_pkg::KMS_OFS_STATUS:   rd_mux = {20'h00000, run_s, mon_s, ptr_stop_ff, ptr_run_ff,
                                                 display_slot_out, 1'b0, display_source_out};
            default: mapped = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys_in or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out  <= 32'h0000_0000;
        end else begin
            pready_out  <= acc && !pready_out;
            pslverr_out <= acc && !pready_out && !mapped;
            if (acc && !pready_out && !pwrite_in) begin
                prdata_out <= rd_mux;
            end
        end
    end

    // Writes are clamped into range so the pointer and the scaler never see an illegal code.
    always_ff @(posedge clk_sys_in or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            run_sel_ff  <= kms_pkg::KMS_RST_RUN_SEL;
            stop_sel_ff <= kms_pkg::KMS_RST_STOP_SEL;
            pers_ff     <= kms_pkg::KMS_RST_PERS;
            factor_ff   <= kms_pkg::KMS_RST_FACTOR;
            decimals_ff <= kms_pkg::KMS_RST_DECIMALS;
            unit_ff     <= kms_pkg::KMS_RST_UNIT;
        end else if (wr_en) begin
            unique case (paddr_in)
                kms_pkg::KMS_OFS_RUN_SEL:  run_sel_ff  <= clamp_sel(wdata16);
                kms_pkg::KMS_OFS_STOP_SEL: stop_sel_ff <= clamp_sel(wdata16);
                kms_pkg::KMS_OFS_PERS: begin
                    pers_ff <= {8'h00,
                                (wdata16[7:4] > kms_pkg::KMS_PTR_MODE_MAX) ? kms_pkg::KMS_PTR_MODE_MAX : wdata16[7:4],
                                (wdata16[3:0] > kms_pkg::KMS_QE_MAX) ? kms_pkg::KMS_QE_MAX : wdata16[3:0]};
                end
                kms_pkg::KMS_OFS_FACTOR:
                    factor_ff <= clamp_rng(wdata16, kms_pkg::KMS_FACTOR_MIN, kms_pkg::KMS_FACTOR_MAX);
                kms_pkg::KMS_OFS_DECIMALS:
                    decimals_ff <= clamp_rng(wdata16, 16'h0000, kms_pkg::KMS_DECIMALS_MAX);
                kms_pkg::KMS_OFS_UNIT:
                    unit_ff <= clamp_rng(wdata16, 16'h0000, kms_pkg::KMS_UNIT_MAX);
                default: ;
            endcase
        end
    end

    assign act_sel = run_s ? run_sel_ff : stop_sel_ff;
    assign act_ptr = run_s ? ptr_run_ff : ptr_stop_ff;
    assign cur_nib = act_sel[{act_ptr, 2'b00} +: 4];

    assign ptr_bus.sel = act_sel;
    assign ptr_bus.cur = act_ptr;

    kms_ptr_step u_step (
        .ptr (ptr_bus.step)
    );

    always_ff @(posedge clk_sys_in or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            ptr_run_ff  <= kms_pkg::KMS_PTR_RST;
            ptr_stop_ff <= kms_pkg::KMS_PTR_RST;
        end else if (state_evt) begin
            if (ptr_mode == kms_pkg::KMS_PTR_MODE_MAX) begin
                if (run_s) begin
                    ptr_run_ff <= kms_pkg::KMS_PTR_RST;
                end else begin
                    ptr_stop_ff <= kms_pkg::KMS_PTR_RST;
                end
            end
        end else if (shift_rise && mon_s && ptr_bus.any_nz) begin
            if (run_s) begin
                ptr_run_ff <= ptr_bus.nxt;
            end else begin
                ptr_stop_ff <= ptr_bus.nxt;
            end
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            display_slot_out   <= kms_pkg::KMS_PTR_RST;
            display_source_out <= 3'h0;
        end else begin
            display_slot_out   <= act_ptr;
            display_source_out <= cur_nib[2:0];
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            quick_edit_req_out    <= 1'b0;
            quick_edit_target_out <= 2'h0;
        end else begin
            quick_edit_req_out    <= enter_rise && mon_s && freq_shown_in && (qe_target != 4'h0);
            quick_edit_target_out <= qe_target[1:0];
        end
    end

    // Two pipeline stages keep the wide multiply and the constant divide apart.
    always_comb begin
        unique case (decimals_ff[1:0])
            2'h0: pow_sel = kms_pkg::KMS_POW0;
            2'h1: pow_sel = kms_pkg::KMS_POW1;
            2'h2: pow_sel = kms_pkg::KMS_POW2;
            2'h3: pow_sel = kms_pkg::KMS_POW3;
        endcase
    end

    assign scaled   = {10'h000, product_ff} * {32'h0000_0000, pow_sel};
    assign quotient = scaled / {32'h0000_0000, kms_pkg::KMS_FACTOR_ONE};

    always_ff @(posedge clk_sys_in or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            product_ff <= 32'h0000_0000;
            readout_ff <= 16'h0000;
        end else begin
            product_ff <= {16'h0000, speed_monitor_in} * {16'h0000, factor_ff};
            // The display has five digits at most, so the readout saturates instead of wrapping.
            readout_ff <= (quotient > 42'h000_0000_ffff) ? 16'hffff : quotient[15:0];
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            load_speed_out     <= 16'h0000;
            decimal_places_out <= 2'h0;
            speed_unit_rpm_out <= 1'b0;
        end else begin
            load_speed_out     <= readout_ff;
            decimal_places_out <= decimals_ff[1:0];
            speed_unit_rpm_out <= unit_ff[0];
        end
    end

    chk_skip_zero: assert property (@(posedge clk_sys_in) disable iff (!rst_sync_ff)
        (shift_rise && mon_s && !state_evt && ptr_bus.any_nz) |=> (cur_nib != 4'h0))
        else $error("pointer landed on a zero slot");

    chk_shift_step: assert property (@(posedge clk_sys_in) disable iff (!rst_sync_ff)
        (shift_rise && mon_s && !state_evt && ptr_bus.any_nz && (cur_nib == 4'h0)) |=>
        (act_ptr != $past(act_ptr)))
        else $error("shift did not leave an empty slot");

    chk_state_split: assert property (@(posedge clk_sys_in) disable iff (!rst_sync_ff)
        (shift_rise && mon_s && !state_evt && run_s) |=> $stable(ptr_stop_ff))
        else $error("run shift moved the stop pointer");

    chk_select_use: assert property (@(posedge clk_sys_in) disable iff (!rst_sync_ff)
        (run_s && $stable(run_s) && $stable(ptr_run_ff)) |->
        (display_source_out == run_sel_ff[{ptr_run_ff, 2'b00} +: 3]) || !$stable(run_sel_ff))
        else $error("display not taken from run selection");

    chk_ptr_reset: assert property (@(posedge clk_sys_in) disable iff (!rst_sync_ff)
        (state_evt && ptr_mode == 4'h1) |=> ##1 (display_slot_out == 2'h0) || !$stable(run_s))
        else $error("pointer not reset on screen change");

    chk_ptr_keep: assert property (@(posedge clk_sys_in) disable iff (!rst_sync_ff)
        (state_evt && ptr_mode == 4'h0) |=> ($stable(ptr_run_ff) && $stable(ptr_stop_ff)))
        else $error("recorded pointer lost on screen change");

    chk_power_on: assert property (@(posedge clk_sys_in)
        $rose(rst_sync_ff) |-> (ptr_run_ff == 2'h0 && ptr_stop_ff == 2'h0))
        else $error("pointers not at ones digit after reset");

    chk_digit_range: assert property (@(posedge clk_sys_in) disable iff (!rst_sync_ff)
        ((run_sel_ff | stop_sel_ff) & 16'h8888) == 16'h0000)
        else $error("selection digit above seven");

    chk_quick_edit: assert property (@(posedge clk_sys_in) disable iff (!rst_sync_ff)
        quick_edit_req_out |-> ($past(enter_rise) && $past(freq_shown_in) && quick_edit_target_out != 2'h0))
        else $error("quick edit without cause");

    chk_factor_range: assert property (@(posedge clk_sys_in) disable iff (!rst_sync_ff)
        (factor_ff >= 16'h0001) && (factor_ff <= 16'hfde8))
        else $error("scale factor out of range");

    chk_dp_range: assert property (@(posedge clk_sys_in) disable iff (!rst_sync_ff)
        decimals_ff <= 16'h0003)
        else $error("decimal places out of range");

    chk_readout_math: assert property (@(posedge clk_sys_in) disable iff (!rst_sync_ff)
        $stable(factor_ff) ##1 (decimals_ff == 16'h0000 && $stable(factor_ff)) ##1 $stable(factor_ff) |->
        (readout_ff == 16'hffff) || (readout_ff == 16'(($past(speed_monitor_in, 2) * $past(factor_ff)) / 1000)))
        else $error("readout does not match speed times factor");

    cov_shift_wrap: cover property (@(posedge clk_sys_in) disable iff (!rst_sync_ff)
        (shift_rise && act_ptr == 2'h3) ##1 (act_ptr == 2'h0));
    cov_quick_edit: cover property (@(posedge clk_sys_in) disable iff (!rst_sync_ff) quick_edit_req_out);
    cov_run_change: cover property (@(posedge clk_sys_in) disable iff (!rst_sync_ff) state_evt && run_s);
    cov_apb_error:  cover property (@(posedge clk_sys_in) disable iff (!rst_sync_ff) pready_out && pslverr_out);
endmodule

// ==== inc/kms_pkg.sv ====
// Constants and register map of the keypad monitor selector.
package kms_pkg;
    localparam logic [7:0]  KMS_OFS_RUN_SEL    = 8'h00;
    localparam logic [7:0]  KMS_OFS_STOP_SEL   = 8'h04;
    localparam logic [7:0]  KMS_OFS_PERS       = 8'h08;
    localparam logic [7:0]  KMS_OFS_FACTOR     = 8'h0c;
    localparam logic [7:0]  KMS_OFS_DECIMALS   = 8'h10;
    localparam logic [7:0]  KMS_OFS_READOUT    = 8'h14;
    localparam logic [7:0]  KMS_OFS_UNIT       = 8'h18;
    localparam logic [7:0]  KMS_OFS_STATUS     = 8'h1c;

    localparam logic [15:0] KMS_RST_RUN_SEL    = 16'h5321;
    localparam logic [15:0] KMS_RST_STOP_SEL   = 16'h0052;
    localparam logic [15:0] KMS_RST_PERS       = 16'h0001;
    localparam logic [15:0] KMS_RST_FACTOR     = 16'h7530;
    localparam logic [15:0] KMS_RST_DECIMALS   = 16'h0000;
    localparam logic [15:0] KMS_RST_UNIT       = 16'h0000;

    localparam logic [15:0] KMS_FACTOR_MIN     = 16'h0001;
    localparam logic [15:0] KMS_FACTOR_MAX     = 16'hfde8;
    localparam logic [15:0] KMS_DECIMALS_MAX   = 16'h0003;
    localparam logic [15:0] KMS_UNIT_MAX       = 16'h0001;
    localparam logic [3:0]  KMS_DIGIT_MAX      = 4'h7;
    localparam logic [3:0]  KMS_QE_MAX         = 4'h3;
    localparam logic [3:0]  KMS_PTR_MODE_MAX   = 4'h1;

    localparam logic [1:0]  KMS_PTR_RST        = 2'h0;
    localparam int          KMS_SLOTS          = 4;
    localparam int          KMS_DIGIT_W        = 4;
    localparam logic [9:0]  KMS_FACTOR_ONE     = 10'h3e8;
    localparam logic [9:0]  KMS_POW0           = 10'h001;
    localparam logic [9:0]  KMS_POW1           = 10'h00a;
    localparam logic [9:0]  KMS_POW2           = 10'h064;
    localparam logic [9:0]  KMS_POW3           = 10'h3e8;
endpackage

// ==== inc/kms_ptr_if.sv ====
// Carrier between the selector and its pointer stepper.
`timescale 1ns/100ps
interface kms_ptr_if;
    logic [15:0] sel;
    logic [1:0]  cur;
    logic [1:0]  nxt;
    logic        any_nz;
    modport step (input sel, input cur, output nxt, output any_nz);
    modport user (output sel, output cur, input nxt, input any_nz);
endinterface

// ==== sim/kms_operator.sv ====
// Operator model: keypad keys and screen state seen by the selector.
`timescale 1ns/100ps
module kms_operator (
    input  wire logic clk_in,
    output logic      key_shift_out,
    output logic      key_enter_out,
    output logic      running_out,
    output logic      monitor_screen_out,
    output logic      freq_shown_out
);
    initial begin
        key_shift_out      = 1'b0;
        key_enter_out      = 1'b0;
        running_out        = 1'b0;
        monitor_screen_out = 1'b1;
        freq_shown_out     = 1'b0;
    end

    // Keys are held past the pin synchroniser, then released long enough to be seen low.
    task automatic press(input logic enter);
        @(posedge clk_in);
        key_enter_out <= enter;
        key_shift_out <= ~enter;
        repeat (4) @(posedge clk_in);
        key_enter_out <= 1'b0;
        key_shift_out <= 1'b0;
        repeat (6) @(posedge clk_in);
    endtask

    task automatic set_state(input logic run, input logic scr, input logic freq);
        @(posedge clk_in);
        running_out        <= run;
        monitor_screen_out <= scr;
        freq_shown_out     <= freq;
        repeat (8) @(posedge clk_in);
    endtask
endmodule

// ==== sim/kms_top_tb.sv ====
// Self-checking bench for the keypad monitor selector.
`timescale 1ns/100ps
module kms_top_tb;
    logic        clk_sys_in       = 1'b0;
    logic        rst_n_in         = 1'b0;
    logic        psel_in;
    logic        penable_in;
    logic        pwrite_in;
    logic [7:0]  paddr_in;
    logic [31:0] pwdata_in;
    logic [15:0] speed_monitor_in;
    logic [31:0] prdata_out;
    logic        pready_out;
    logic        pslverr_out;
    logic        key_shift;
    logic        key_enter;
    logic        running;
    logic        monitor_screen;
    logic        freq_shown;
    logic [1:0]  display_slot_out;
    logic [2:0]  display_source_out;
    logic        quick_edit_req_out;
    logic [1:0]  quick_edit_target_out;
    logic [15:0] load_speed_out;
    logic [1:0]  decimal_places_out;
    logic        speed_unit_rpm_out;
    logic [31:0] rd;
    logic        err;
    int          bad_count = 0;
    int          tests_run = 0;
    int          cycles    = 0;
    int          qe_count  = 0;
    int          qe_base   = 0;
    logic [7:0]  ofs [6] = '{kms_pkg::KMS_OFS_RUN_SEL, kms_pkg::KMS_OFS_STOP_SEL, kms_pkg::KMS_OFS_PERS,
                             kms_pkg::KMS_OFS_FACTOR, kms_pkg::KMS_OFS_DECIMALS, kms_pkg::KMS_OFS_UNIT};
    logic [31:0] rstv [6] = '{32'h5321, 32'h0052, 32'h0001, 32'h7530, 32'h0, 32'h0};

    kms_top i_dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .psel_in(psel_in), .penable_in(penable_in),
        .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
        .pready_out(pready_out), .pslverr_out(pslverr_out), .key_shift_in(key_shift), .key_enter_in(key_enter),
        .running_in(running), .monitor_screen_in(monitor_screen), .freq_shown_in(freq_shown),
        .speed_monitor_in(speed_monitor_in), .display_slot_out(display_slot_out),
        .display_source_out(display_source_out), .quick_edit_req_out(quick_edit_req_out),
        .quick_edit_target_out(quick_edit_target_out), .load_speed_out(load_speed_out),
        .decimal_places_out(decimal_places_out), .speed_unit_rpm_out(speed_unit_rpm_out));

    kms_operator i_op (.clk_in(clk_sys_in), .key_shift_out(key_shift), .key_enter_out(key_enter),
        .running_out(running), .monitor_screen_out(monitor_screen), .freq_shown_out(freq_shown));

    always #2 clk_sys_in = ~clk_sys_in;

    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // The whole sequence needs under a thousand cycles, so this ceiling only cuts a hang.
    always @(posedge clk_sys_in) begin
        cycles++;
        if (quick_edit_req_out === 1'b1) begin
            qe_count++;
        end
        if (cycles == 20000) begin
            bad_count++;
            complete_run;
        end
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("FAIL %s expected %h seen %h", name, exp, got);
            bad_count++;
        end
    endtask

    // The request stands until ready is seen high at a rising edge; data and error are taken at that edge.
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
        @(posedge clk_sys_in);
        psel_in    <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in  <= wr;
        paddr_in   <= addr;
        pwdata_in  <= data;
        @(posedge clk_sys_in);
        penable_in <= 1'b1;
        do begin
            @(posedge clk_sys_in);
        end while (pready_out !== 1'b1);
        rd         = prdata_out;
        err        = pslverr_out;
        psel_in    <= 1'b0;
        penable_in <= 1'b0;
    endtask

    task automatic rdchk(input string name, input logic [7:0] addr, input logic [31:0] exp);
        apb(1'b0, addr, 32'h0);
        chk(name, exp, rd);
    endtask

    task automatic disp(input logic [1:0] slot, input logic [2:0] src);
        chk("display slot", 32'(slot), 32'(display_slot_out));
        chk("display source", 32'(src), 32'(display_source_out));
    endtask

    initial begin
        psel_in          <= 1'b0;
        penable_in       <= 1'b0;
        pwrite_in        <= 1'b0;
        paddr_in         <= 8'h00;
        pwdata_in        <= 32'h0000_0000;
        speed_monitor_in <= 16'h0064;
        repeat (16) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        repeat (6) @(posedge clk_sys_in);
        for (int i = 0; i < 6; i++) begin
            rdchk("reset value", ofs[i], rstv[i]);
        end
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped error", 32'h1, 32'(err));
        chk("unmapped data", 32'h0, rd);
        apb(1'b1, kms_pkg::KMS_OFS_READOUT, 32'h0000abcd);
        rdchk("readout", kms_pkg::KMS_OFS_READOUT, 32'd3000);
        apb(1'b1, kms_pkg::KMS_OFS_FACTOR, 32'h03e8);
        apb(1'b1, kms_pkg::KMS_OFS_DECIMALS, 32'h2);
        speed_monitor_in <= 16'd123;
        repeat (6) @(posedge clk_sys_in);
        rdchk("scaled readout", kms_pkg::KMS_OFS_READOUT, 32'd12300);
        chk("load speed pin", 32'd12300, 32'(load_speed_out));
        chk("decimal pin", 32'h2, 32'(decimal_places_out));
        apb(1'b1, kms_pkg::KMS_OFS_DECIMALS, 32'h5);
        rdchk("decimal clamp", kms_pkg::KMS_OFS_DECIMALS, 32'h3);
        apb(1'b1, kms_pkg::KMS_OFS_FACTOR, 32'h0);
        rdchk("factor low", kms_pkg::KMS_OFS_FACTOR, 32'h1);
        apb(1'b1, kms_pkg::KMS_OFS_FACTOR, 32'hffff);
        rdchk("factor high", kms_pkg::KMS_OFS_FACTOR, 32'hfde8);
        apb(1'b1, kms_pkg::KMS_OFS_UNIT, 32'h1);
        repeat (2) @(posedge clk_sys_in);
        chk("rpm pin", 32'h1, 32'(speed_unit_rpm_out));
        disp(2'h0, 3'h2);
        i_op.press(1'b0);
        disp(2'h1, 3'h5);
        i_op.press(1'b0);
        disp(2'h0, 3'h2);
        i_op.press(1'b0);
        i_op.set_state(1'b1, 1'b1, 1'b0);
        disp(2'h0, 3'h1);
        i_op.press(1'b0);
        i_op.press(1'b0);
        disp(2'h2, 3'h3);
        i_op.set_state(1'b0, 1'b1, 1'b0);
        disp(2'h1, 3'h5);
        i_op.set_state(1'b1, 1'b1, 1'b0);
        disp(2'h2, 3'h3);
        apb(1'b1, kms_pkg::KMS_OFS_PERS, 32'hffff_0011);
        i_op.set_state(1'b0, 1'b1, 1'b0);
        disp(2'h0, 3'h2);
        i_op.press(1'b0);
        i_op.set_state(1'b0, 1'b0, 1'b0);
        i_op.set_state(1'b0, 1'b1, 1'b0);
        disp(2'h0, 3'h2);
        apb(1'b1, kms_pkg::KMS_OFS_STOP_SEL, 32'h9000);
        rdchk("digit clamp", kms_pkg::KMS_OFS_STOP_SEL, 32'h7000);
        i_op.press(1'b0);
        disp(2'h3, 3'h7);
        i_op.press(1'b0);
        disp(2'h3, 3'h7);
        i_op.set_state(1'b0, 1'b1, 1'b1);
        for (int t = 0; t < 4; t++) begin
            apb(1'b1, kms_pkg::KMS_OFS_PERS, 32'(t));
            qe_base = qe_count;
            i_op.press(1'b1);
            chk("quick edit count", (t != 0) ? 32'h1 : 32'h0, 32'(qe_count - qe_base));
            chk("quick edit target", 32'(t), 32'(quick_edit_target_out));
        end
        i_op.set_state(1'b0, 1'b1, 1'b0);
        qe_base = qe_count;
        i_op.press(1'b1);
        chk("quick edit off frequency", 32'h0, 32'(qe_count - qe_base));
        complete_run;
    end
endmodule
